// ### logic/pbc_clock_gen.sv
// Behaviour
// - VCO equals reference times 2^P times N over R
// - Phase compare runs on reference divided by R
// - Bus clock is quarter of selected source
// - Center frequency is L times 2^E times nominal
// - Zero divider or multiplier acts as one
// - Zero L disables PLL, forces crystal
// - Switch waits three edges of each source (none of a dead VCO), output static
// - Switch output halved for even duty
// - VCO selection refused while PLL off
// - PLL off refused while VCO selected
// - Enable and selection never change together
// - Select one gives VCO half, zero crystal
// - Reset clears select, sets PLL enable
// - Prescaler ignores writes while PLL on
`timescale 1ns/1ps
module pbc_clock_gen #(
  parameter int MULT_W = 12,
  parameter int REF_W  = 4,
  parameter int RNG_W  = 8
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Source clocks, oversampled
  input  wire logic        crystal_clock,
  input  wire logic        vco_clock,
  // Clock outputs
  output logic             base_clock_out,
  output logic             bus_clock_out,
  // Loop control toward the analog section
  output logic             pll_power_on,
  output logic             pump_up,
  output logic             pump_down,
  output logic      [31:0] vco_center_hz,
  output logic             switch_busy
);

  localparam int FB_W = MULT_W + 3;

  typedef struct packed {
    logic                  on;
    logic                  sel;
    logic [1:0]            pre;
    logic [1:0]            vco_range_power_field;
    logic [MULT_W-1:0]     mult;
    logic [RNG_W-1:0]      range;
    logic [REF_W-1:0]      refdiv;
    logic                  cur_src;
    pbc_pkg::pbc_sw_state_t sw;
    logic [1:0]            cnt;
    logic                  base;
    logic                  bus;
    logic                  up;
    logic                  dn;
    logic [31:0]           rdata;
    logic [31:0]           center;
  } pbc_state_t;

  pbc_state_t st_ff;
  pbc_state_t nxt_st;

  logic [1:0]        src_rise;
  logic              xtal_rise;
  logic              vco_rise;
  logic              ref_tick;
  logic              fb_tick;
  logic [REF_W-1:0]  eff_r;
  logic [MULT_W-1:0] eff_n;
  logic [FB_W-1:0]   fb_div;
  logic              pll_active;
  logic              cur_rise;
  logic              hit;
  logic              wr_acc;
  logic              rd_setup;
  logic [31:0]       rd_word;
  logic [31:0]       span;

  // ==========================================================================
  // Source clock sampling
  pbc_edge_sync #(
    .W (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({vco_clock, crystal_clock}),
    .rise     (src_rise)
  );

  assign xtal_rise = src_rise[0];
  assign vco_rise  = src_rise[1];

  // Zero divisors collapse to one so no counter ever wraps on zero
  assign eff_r      = (st_ff.refdiv == '0) ? REF_W'(1) : st_ff.refdiv;
  assign eff_n      = (st_ff.mult == '0) ? MULT_W'(1) : st_ff.mult;
  assign fb_div     = FB_W'(eff_n) << st_ff.pre;
  assign pll_active = st_ff.on && (st_ff.range != '0);

  // ==========================================================================
  // Reference and feedback dividers feeding the phase comparator
  pbc_tick_div #(
    .W (REF_W)
  ) u_ref_div (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (pll_active),
    .tick    (xtal_rise),
    .divisor (eff_r),
    .pulse   (ref_tick)
  );

  pbc_tick_div #(
    .W (FB_W)
  ) u_fb_div (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (pll_active),
    .tick    (vco_rise),
    .divisor (fb_div),
    .pulse   (fb_tick)
  );

  // ==========================================================================
  // APB decode; zero wait states, so the access phase always completes
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign cur_rise = st_ff.cur_src ? vco_rise : xtal_rise;
  assign span     = 32'(st_ff.range) << st_ff.vco_range_power_field;

  always_comb begin
    hit     = 1'b1;
    rd_word = '0;
    case (paddr)
      pbc_pkg::ADDR_CTRL: begin
        rd_word[pbc_pkg::CTRL_ON_BIT]                    = st_ff.on;
        rd_word[pbc_pkg::CTRL_SEL_BIT]                   = st_ff.sel;
        rd_word[pbc_pkg::CTRL_PRE_LSB +: 2]              = st_ff.pre;
        rd_word[pbc_pkg::CTRL_VPR_LSB +: 2]              = st_ff.vco_range_power_field;
      end
      pbc_pkg::ADDR_MULT_HI: rd_word[MULT_W-9:0] = st_ff.mult[MULT_W-1:8];
      pbc_pkg::ADDR_MULT_LO: rd_word[7:0]        = st_ff.mult[7:0];
      pbc_pkg::ADDR_RANGE:   rd_word[RNG_W-1:0]  = st_ff.range;
      pbc_pkg::ADDR_REFDIV:  rd_word[REF_W-1:0]  = st_ff.refdiv;
      pbc_pkg::ADDR_STATUS: begin
        rd_word[pbc_pkg::STAT_SRC_BIT] = st_ff.cur_src;
        rd_word[pbc_pkg::STAT_BSY_BIT] = (st_ff.sw != pbc_pkg::SW_RUN);
        rd_word[pbc_pkg::STAT_ACT_BIT] = pll_active;
      end
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next-state logic: registers, interlocks, clock switch, comparator
  always_comb begin
    logic w_on;
    logic w_sel;
    logic tgt;
    w_on   = pwdata[pbc_pkg::CTRL_ON_BIT];
    w_sel  = pwdata[pbc_pkg::CTRL_SEL_BIT];
    tgt    = 1'b0;
    nxt_st = st_ff;

    // Read data is captured in the setup cycle so it comes from a flop
    if (rd_setup) begin
      nxt_st.rdata = rd_word;
    end

    // Register writes take effect at the access edge
    if (wr_acc) begin
      case (paddr)
        pbc_pkg::ADDR_CTRL: begin
          if ((w_on != st_ff.on) && (w_sel != st_ff.sel)) begin
            nxt_st.on  = st_ff.on;
            nxt_st.sel = st_ff.sel;
          end else begin
            if (!(st_ff.sel && !w_on)) begin
              nxt_st.on = w_on;
            end
            if (!(w_sel && !st_ff.on)) begin
              nxt_st.sel = w_sel;
            end
          end
          // Prescaler and range power are frozen while the loop runs
          if (!st_ff.on) begin
            nxt_st.pre = pwdata[pbc_pkg::CTRL_PRE_LSB +: 2];
            nxt_st.vco_range_power_field = pwdata[pbc_pkg::CTRL_VPR_LSB +: 2];
          end
        end
        pbc_pkg::ADDR_MULT_HI: nxt_st.mult[MULT_W-1:8] = pwdata[MULT_W-9:0];
        pbc_pkg::ADDR_MULT_LO: nxt_st.mult[7:0]        = pwdata[7:0];
        pbc_pkg::ADDR_RANGE:   nxt_st.range            = pwdata[RNG_W-1:0];
        pbc_pkg::ADDR_REFDIV:  nxt_st.refdiv           = pwdata[REF_W-1:0];
        default: ;
      endcase
    end

    // A zero linear factor can never leave the VCO selected
    if (nxt_st.range == '0) begin
      nxt_st.sel = 1'b0;
    end

    // Source the output should follow; VCO only while the loop is usable
    tgt = st_ff.sel && pll_active;

    case (st_ff.sw)
      pbc_pkg::SW_RUN: begin
        // Leave only from a low output phase, so no runt high pulse escapes;
        // a dead VCO never brings that phase, so it is left at once
        if ((tgt != st_ff.cur_src) &&
            (!st_ff.base || (st_ff.cur_src && !pll_active))) begin
          nxt_st.sw   = pbc_pkg::SW_DRAIN_OLD;
          nxt_st.cnt  = '0;
          nxt_st.base = 1'b0;
        end else if (cur_rise) begin
          nxt_st.base = !st_ff.base;
        end
      end
      pbc_pkg::SW_DRAIN_OLD: begin
        nxt_st.base = 1'b0;
        // A VCO that has been shut down cannot be drained, so skip it
        if ((cur_rise && st_ff.cnt == pbc_pkg::SW_LAST_EDGE) ||
            (st_ff.cur_src && !pll_active)) begin
          nxt_st.cur_src = !st_ff.cur_src;
          nxt_st.sw      = pbc_pkg::SW_WAIT_NEW;
          nxt_st.cnt     = '0;
        end else if (cur_rise) begin
          nxt_st.cnt = st_ff.cnt + 2'h1;
        end
      end
      pbc_pkg::SW_WAIT_NEW: begin
        nxt_st.base = 1'b0;
        if (cur_rise && st_ff.cnt == pbc_pkg::SW_LAST_EDGE) begin
          nxt_st.sw  = pbc_pkg::SW_RUN;
          nxt_st.cnt = '0;
        end else if (cur_rise) begin
          nxt_st.cnt = st_ff.cnt + 2'h1;
        end
      end
      default: begin
        nxt_st.sw   = pbc_pkg::SW_RUN;
        nxt_st.base = 1'b0;
      end
    endcase

    // Bus clock toggles on each base rising edge: quarter of the source
    if (!st_ff.base && nxt_st.base) begin
      nxt_st.bus = !st_ff.bus;
    end

    // Three-state phase detector; both pending means equal phase
    if (!pll_active || (st_ff.up && st_ff.dn)) begin
      nxt_st.up = 1'b0;
      nxt_st.dn = 1'b0;
    end else begin
      nxt_st.up = st_ff.up || ref_tick;
      nxt_st.dn = st_ff.dn || fb_tick;
    end

    // Center-of-range frequency in hertz
    nxt_st.center = 32'(span * pbc_pkg::F_NOM_HZ);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;
      st_ff.on      <= pbc_pkg::RST_ON;
      st_ff.sel     <= pbc_pkg::RST_SEL;
      st_ff.pre     <= pbc_pkg::RST_PRE;
      st_ff.vco_range_power_field     <= pbc_pkg::RST_VPR;
      st_ff.mult    <= {pbc_pkg::RST_MULT_H, pbc_pkg::RST_MULT_L};
      st_ff.range   <= pbc_pkg::RST_RANGE;
      st_ff.refdiv  <= pbc_pkg::RST_REFDIV;
      st_ff.sw      <= pbc_pkg::SW_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata         = st_ff.rdata;
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !hit;
  assign base_clock_out = st_ff.base;
  assign bus_clock_out  = st_ff.bus;
  assign pll_power_on   = pll_active;
  assign pump_up        = st_ff.up;
  assign pump_down      = st_ff.dn;
  assign vco_center_hz  = st_ff.center;
  assign switch_busy    = (st_ff.sw != pbc_pkg::SW_RUN);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ctrl_wr;
  assign ctrl_wr = wr_acc && (paddr == pbc_pkg::ADDR_CTRL);

  chk_sel_needs_on: assert property (st_ff.sel |-> st_ff.on)
    else $error("VCO selected while PLL off");
  chk_zero_l_xtal: assert property ((st_ff.range == '0) && (st_ff.sw == pbc_pkg::SW_RUN) |=>
    !st_ff.sel && (!st_ff.cur_src || (st_ff.sw != pbc_pkg::SW_RUN)))
    else $error("Zero linear factor left VCO selected");
  chk_no_dual_change: assert property (ctrl_wr && (pwdata[pbc_pkg::CTRL_ON_BIT] != st_ff.on)
    && (pwdata[pbc_pkg::CTRL_SEL_BIT] != st_ff.sel) |=>
    (st_ff.on == $past(st_ff.on)) && (st_ff.sel == $past(st_ff.sel)))
    else $error("Enable and select changed together");
  chk_pre_frozen: assert property (ctrl_wr && st_ff.on |=> $stable(st_ff.pre))
    else $error("Prescaler written while PLL on");
  chk_hold_low: assert property ((st_ff.sw != pbc_pkg::SW_RUN) |-> !st_ff.base)
    else $error("Base clock moved during switch");
  chk_base_toggle: assert property ((st_ff.sw == pbc_pkg::SW_RUN) && cur_rise &&
    (st_ff.base || (st_ff.sel && pll_active) == st_ff.cur_src) |=>
    st_ff.base != $past(st_ff.base))
    else $error("Base clock missed a source edge");
  chk_bus_quarter: assert property ($rose(st_ff.base) |-> st_ff.bus != $past(st_ff.bus))
    else $error("Bus clock did not follow base clock");
  chk_div_nonzero: assert property ((eff_r != '0) && (eff_n != '0) &&
    ((st_ff.refdiv == '0) -> (eff_r == REF_W'(1))))
    else $error("Zero divisor reached a counter");
  chk_switch_ends: assert property ((st_ff.sw == pbc_pkg::SW_WAIT_NEW) && cur_rise &&
    (st_ff.cnt == pbc_pkg::SW_LAST_EDGE) |=> (st_ff.sw == pbc_pkg::SW_RUN))
    else $error("Switch did not finish on third new edge");

  cov_to_vco: cover property ((st_ff.sw == pbc_pkg::SW_WAIT_NEW) && st_ff.cur_src
    ##1 (st_ff.sw == pbc_pkg::SW_RUN));
  cov_to_xtal: cover property ((st_ff.sw == pbc_pkg::SW_WAIT_NEW) && !st_ff.cur_src
    ##1 (st_ff.sw == pbc_pkg::SW_RUN));
  cov_refused_off: cover property (ctrl_wr && st_ff.sel && !pwdata[pbc_pkg::CTRL_ON_BIT]);

endmodule // pbc_clock_gen

// ### logic/pbc_edge_sync.sv
`timescale 1ns/1ps
module pbc_edge_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Foreign levels and their filtered rising edges
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
  } pbc_sync_t;

  pbc_sync_t st_ff;
  pbc_sync_t nxt_st;

  // ==========================================================================
  // Three-stage chain; level moves only when stages two and three agree
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.lvl[i] = st_ff.s3[i];
      end
    end
    nxt_st.rise = nxt_st.lvl & ~st_ff.lvl;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise = st_ff.rise;

endmodule // pbc_edge_sync

// ### logic/pbc_pkg.sv
package pbc_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_MULT_HI = 8'h04;
  localparam logic [7:0] ADDR_MULT_LO = 8'h08;
  localparam logic [7:0] ADDR_RANGE   = 8'h0c;
  localparam logic [7:0] ADDR_REFDIV  = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_ON_BIT  = 5;
  localparam int CTRL_SEL_BIT = 4;
  localparam int CTRL_PRE_LSB = 2;
  localparam int CTRL_VPR_LSB = 0;

  // Status register fields
  localparam int STAT_SRC_BIT = 0;
  localparam int STAT_BSY_BIT = 1;
  localparam int STAT_ACT_BIT = 2;

  // ==========================================================================
  // Reset values
  localparam logic       RST_ON     = 1'b1;
  localparam logic       RST_SEL    = 1'b0;
  localparam logic [1:0] RST_PRE    = 2'h0;
  localparam logic [1:0] RST_VPR    = 2'h0;
  localparam logic [7:0] RST_RANGE  = 8'h40;
  localparam logic [7:0] RST_MULT_L = 8'h40;
  localparam logic [3:0] RST_MULT_H = 4'h0;
  localparam logic [3:0] RST_REFDIV = 4'h1;

  // ==========================================================================
  // Timing and frequency constants
  localparam logic [1:0]  SW_LAST_EDGE = 2'h2;       // Third edge ends a wait phase
  localparam logic [31:0] F_NOM_HZ     = 32'd38400;  // Nominal center-of-range step

  // Clock switch sequencer states
  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN_OLD,
    SW_WAIT_NEW
  } pbc_sw_state_t;

endpackage

// ### logic/pbc_tick_div.sv
`timescale 1ns/1ps
module pbc_tick_div #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Tick stream and divisor (never zero)
  input  wire logic         enable,
  input  wire logic         tick,
  input  wire logic [W-1:0] divisor,
  output logic              pulse
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } pbc_div_t;

  pbc_div_t st_ff;
  pbc_div_t nxt_st;

  // ==========================================================================
  // One output pulse per divisor ticks; idle clears the count for a clean start
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.pulse = 1'b0;
    if (!enable) begin
      nxt_st.cnt = '0;
    end else if (tick) begin
      if (st_ff.cnt >= divisor - W'(1)) begin
        nxt_st.cnt   = '0;
        nxt_st.pulse = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse = st_ff.pulse;

endmodule // pbc_tick_div

// ### testbench/pbc_far_end.sv
`timescale 1ns/1ps
// ==========================================================================
// Far side: source clocks in, base and bus clocks measured as they are used
module pbc_far_end #(
  parameter int XTAL_HALF = 160,
  parameter int VCO_HALF  = 240
) (
  // Loop state from the block
  input  wire logic        pll_power_on,
  // Source clocks toward the block
  output logic             crystal_clock,
  output logic             vco_clock,
  // Consumed clocks and their last measured periods in ns
  input  wire logic        base_clock_out,
  input  wire logic        bus_clock_out,
  output logic      [31:0] base_period_ff,
  output logic      [31:0] bus_period_ff
);
  time base_last;
  time bus_last;

  // Crystal runs free; offset keeps its edges away from pclk edges
  initial begin
    crystal_clock = 1'b0;
    #7;
    forever #XTAL_HALF crystal_clock = ~crystal_clock;
  end

  // The oscillator dies when the loop is off, as a real one would
  initial begin
    vco_clock = 1'b0;
    #13;
    forever begin
      #VCO_HALF;
      if (pll_power_on === 1'b1) vco_clock = ~vco_clock;
      else vco_clock = 1'b0;
    end
  end

  // Period measurement between rising edges
  initial begin
    base_last = 0;
    bus_last = 0;
    base_period_ff = 32'h0;
    bus_period_ff = 32'h0;
  end
  always @(posedge base_clock_out) begin
    base_period_ff = 32'($time - base_last);
    base_last = $time;
  end
  always @(posedge bus_clock_out) begin
    bus_period_ff = 32'($time - bus_last);
    bus_last = $time;
  end
endmodule // pbc_far_end

// ### testbench/pll_divider_base_clock_select_test.sv
`timescale 1ns/1ps
module pll_divider_base_clock_select_test;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, vco_center_hz, base_period_ff, bus_period_ff, rd;
  logic        pready, pslverr, crystal_clock, vco_clock, base_clock_out, bus_clock_out;
  logic        pll_power_on, pump_up, pump_down, switch_busy, err;
  int          num_errors, tests_run;

  // ==========================================================================
  // Design and far side
  pbc_clock_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_clock(crystal_clock), .vco_clock(vco_clock),
    .base_clock_out(base_clock_out), .bus_clock_out(bus_clock_out),
    .pll_power_on(pll_power_on), .pump_up(pump_up), .pump_down(pump_down),
    .vco_center_hz(vco_center_hz), .switch_busy(switch_busy));
  pbc_far_end far (.pll_power_on(pll_power_on), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .base_clock_out(base_clock_out), .bus_clock_out(bus_clock_out),
    .base_period_ff(base_period_ff), .bus_period_ff(bus_period_ff));

  // ==========================================================================
  // Clock, 40 ns period
  always #20 pclk = ~pclk;

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // APB transfer: held until pready is seen high at a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask

  // Switch must start, keep the base clock low, and finish in bounded time
  task switch_watch(input string name);
    int n;
    logic moved;
    n = 0;
    moved = 1'b0;
    while (switch_busy !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check({name, "_start"}, 32'h1, 32'(switch_busy));
    n = 0;
    while (switch_busy === 1'b1 && n < 300) begin
      if (base_clock_out !== 1'b0) moved = 1'b1;
      @(posedge pclk);
      n++;
    end
    check({name, "_static"}, 32'h0, 32'(moved));
    check({name, "_done"}, 32'h0, 32'(switch_busy));
  endtask

  // Base is half and bus a quarter of the source rate
  task measure(input string name, input logic [31:0] src);
    repeat (4) @(posedge bus_clock_out);
    check({name, "_base"}, 2 * src, base_period_ff);
    check({name, "_bus"}, 4 * src, bus_period_ff);
  endtask

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #400us;
    num_errors++;
    close_out();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;

    rd_chk("ctrl_rst", pbc_pkg::ADDR_CTRL, 32'h20);
    rd_chk("mlo_rst", pbc_pkg::ADDR_MULT_LO, 32'h40);
    rd_chk("mhi_rst", pbc_pkg::ADDR_MULT_HI, 32'h0);
    rd_chk("rng_rst", pbc_pkg::ADDR_RANGE, 32'h40);
    rd_chk("ref_rst", pbc_pkg::ADDR_REFDIV, 32'h1);
    check("on_rst", 32'h1, 32'(pll_power_on));
    check("ctr_rst", 32'h40 * pbc_pkg::F_NOM_HZ, vco_center_hz);
    measure("xtal", 32'd320);
    $display("test reset done");

    // Interlocks on the control word
    wr(pbc_pkg::ADDR_CTRL, 32'h2d);
    rd_chk("pre_frozen", pbc_pkg::ADDR_CTRL, 32'h20);
    wr(pbc_pkg::ADDR_CTRL, 32'h00);
    @(posedge pclk);
    check("off", 32'h0, 32'(pll_power_on));
    wr(pbc_pkg::ADDR_CTRL, 32'h09);
    rd_chk("pre_open", pbc_pkg::ADDR_CTRL, 32'h09);
    repeat (2) @(posedge pclk);
    check("ctr_e1", 32'h80 * pbc_pkg::F_NOM_HZ, vco_center_hz);
    wr(pbc_pkg::ADDR_CTRL, 32'h19);
    rd_chk("sel_refused", pbc_pkg::ADDR_CTRL, 32'h09);
    wr(pbc_pkg::ADDR_CTRL, 32'h39);
    rd_chk("dual_on", pbc_pkg::ADDR_CTRL, 32'h09);
    wr(pbc_pkg::ADDR_CTRL, 32'h29);
    rd_chk("on_again", pbc_pkg::ADDR_CTRL, 32'h29);
    $display("test interlock done");

    // Switch to the oscillator and hold it there
    wr(pbc_pkg::ADDR_CTRL, 32'h39);
    switch_watch("to_vco");
    xfer(1'b0, pbc_pkg::ADDR_STATUS, 32'h0);
    check("src_vco", 32'h1, 32'(rd[pbc_pkg::STAT_SRC_BIT]));
    measure("vco", 32'd480);
    wr(pbc_pkg::ADDR_CTRL, 32'h19);
    rd_chk("off_refused", pbc_pkg::ADDR_CTRL, 32'h39);
    wr(pbc_pkg::ADDR_CTRL, 32'h09);
    rd_chk("dual_off", pbc_pkg::ADDR_CTRL, 32'h39);
    $display("test switch done");

    // A zero linear factor kills the loop and forces the crystal
    wr(pbc_pkg::ADDR_RANGE, 32'h0);
    repeat (2) @(posedge pclk);
    check("l0_off", 32'h0, 32'(pll_power_on));
    check("l0_ctr", 32'h0, vco_center_hz);
    check("l0_pump", 32'h0, 32'({pump_up, pump_down}));
    rd_chk("l0_sel", pbc_pkg::ADDR_CTRL, 32'h29);
    switch_watch("to_xtal");
    measure("xtal2", 32'd320);
    $display("test zero factor done");

    // Unmapped place answers with an error and no data
    xfer(1'b0, 8'h18, 32'h0);
    check("unmap_err", 32'h1, 32'(err));
    check("unmap_data", 32'h0, rd);
    $display("test unmapped done");
    close_out();
  end
endmodule // pll_divider_base_clock_select_test
